// ===== capcmp_timer.sv
// Two channel 16-bit modulo timer with capture, compare and PWM
// What this block does
// - Count clock is bus clock over 2^select for 000..110, external pin for 111.
// - External pin is forced to input while it is the count source.
// - Overflow flag sets on wrap to zero; reset clears it, writing one does nothing.
// - Flag clears by zero write after a read saw it set, unless overflow since.
// - Overflow request is flag and enable; reset clears the enable.
// - Halt bit freezes the counter; reset sets it.
// - Halt also blocks input captures.
// - Counter clear bit zeroes counter and prescaler, reads zero, self clears.
// - Halt and clear written together leave the counter stopped at zero.
// - High byte read latches low byte until low byte is read.
// - At counter equal modulo, next count clock gives zero and the flag sets one cycle later.
// - Modulo high write blocks overflow flag until modulo low is written.
// - Modulo registers reset to all ones.
// - Channel flag sets on active edge or compare match; writing one does nothing.
// - Channel flag clears by zero write after seeing it set, unless event since.
// - Channel request is flag and its enable; reset clears the enable.
// - Channel zero link bit selects buffered mode, disables channel one, frees its pin.
// - With edge field nonzero, mode bit A picks compare or capture; link overrides.
// - Edge field zero leaves pin to port and presets output by mode bit A.
// - Edge field zero disconnects channel; it connects once an operating mode starts.
// - Capture on rising for 01, falling for 10, both for 11.
// - Match toggles for 01, drives low for 10, drives high for 11.
// - Toggle on wrap toggles output at overflow, winning over a match.
// - Full duty bit with toggle on wrap forces 100% from the next period.
// - Buffered mode switches to the last written value pair at each overflow.
// - Value high write in compare mode blocks compares until low is written.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module capcmp_timer (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [7:0] rdata,
  input wire logic ext_count_clock_pin,
  input wire logic port_direction_bit,
  output logic ext_pin_direction,
  input wire logic [1:0] channel_pin_in,
  output logic [1:0] channel_pin_out,
  output logic [1:0] channel_pin_oe,
  output logic [1:0] channel_pin_timer,
  output logic overflow_irq,
  output logic [1:0] channel_irq
);
  import capcmp_timer_pkg::*;

  // Address of one register of a channel
  function automatic logic [3:0] chan_reg(input logic ch, input logic [3:0] ofs);
    chan_reg = ADDR_CH_BASE + (ch ? CH_STRIDE : 4'h0) + ofs;
  endfunction

  // Low bits of the prescaler that must all be one for a tick
  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    div_mask = PRESC_ONES >> (3'h7 - sel);
  endfunction

  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_prev_q;
  logic overflow_flag_q;
  logic overflow_irq_enable_q;
  logic counter_halt_q;
  logic [2:0] count_clock_select_q;
  logic ovf_armed_q;
  logic [6:0] presc_q;
  logic [15:0] cnt_q;
  logic step_q;
  logic wrap_q;
  logic [15:0] mod_q;
  logic mod_lock_q;
  logic [7:0] cnt_buf_q;
  logic cnt_latched_q;
  logic channel_pair_link_q;
  logic active_sel_q;
  logic last_wr_q;
  logic [7:0] rdata_q;

  logic [1:0] channel_event_flag_q;
  logic [1:0] channel_irq_enable_q;
  logic [1:0] channel_mode_bit_a_q;
  logic [1:0] edge_level_q [2];
  logic [1:0] toggle_on_wrap_q;
  logic [1:0] full_duty_force_q;
  logic [15:0] val_q [2];
  logic [1:0] cmp_lock_q;
  logic [1:0] cap_lock_q;
  logic [1:0] ch_armed_q;
  logic [1:0] out_q;
  logic [1:0] max_act_q;

  logic wr_tsc;
  logic rd_tsc;
  logic ovf_clear;
  logic ovf_set;
  logic ext_tick;
  logic int_tick;
  logic count_en;
  logic at_mod;
  logic [1:0] ch_en;
  logic [1:0] capture_mode;
  logic [1:0] compare_mode;
  logic [1:0] match;
  logic [1:0] cap_ev;
  logic [1:0] wr_vlo;

  // Control register strobes
  assign wr_tsc = wr_strobe && (addr == ADDR_TSC);
  assign rd_tsc = rd_strobe && (addr == ADDR_TSC);

  // Pins pass two flip-flops; a third stage holds the previous level for edges
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_prev_q <= 3'h0;
    end else begin
      pin_s1_q <= {ext_count_clock_pin, channel_pin_in};
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // Count tick from the prescaler or from rising edges of the external pin
  assign ext_tick = pin_s2_q[2] & ~pin_prev_q[2];
  assign int_tick = (presc_q & div_mask(count_clock_select_q)) == div_mask(count_clock_select_q);
  assign count_en = ~counter_halt_q & ((count_clock_select_q == PS_EXT) ? ext_tick : int_tick);
  assign at_mod = (cnt_q == mod_q);

  // External pin is an input whenever it feeds the counter
  assign ext_pin_direction = port_direction_bit & (count_clock_select_q != PS_EXT);

  // Overflow flag handshake: the set always beats a pending clear
  assign ovf_set = wrap_q & ~mod_lock_q;
  assign ovf_clear = wr_tsc & ~wdata[TSC_OVF] & ovf_armed_q;

  // Timer status and control register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      overflow_flag_q <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
      counter_halt_q <= HALT_RESET;
      count_clock_select_q <= PS_RESET;
      ovf_armed_q <= 1'b0;
    end else begin
      if (ovf_set) begin
        overflow_flag_q <= 1'b1;
      end else if (ovf_clear) begin
        overflow_flag_q <= 1'b0;
      end
      if (ovf_set) begin
        ovf_armed_q <= 1'b0;
      end else if (rd_tsc && overflow_flag_q) begin
        ovf_armed_q <= 1'b1;
      end else if (wr_tsc) begin
        ovf_armed_q <= 1'b0;
      end
      if (wr_tsc) begin
        overflow_irq_enable_q <= wdata[TSC_OIE];
        counter_halt_q <= wdata[TSC_HALT];
        count_clock_select_q <= wdata[TSC_PS_LSB +: 3];
      end
    end
  end

  assign overflow_irq = overflow_flag_q & overflow_irq_enable_q;

  // Prescaler and counter; a clear write zeroes both and wins over counting
  always_ff @(posedge clock) begin
    if (!nrst) begin
      presc_q <= 7'h00;
      cnt_q <= CNT_RESET;
      step_q <= 1'b0;
      wrap_q <= 1'b0;
    end else if (wr_tsc && wdata[TSC_CLR]) begin
      presc_q <= 7'h00;
      cnt_q <= CNT_RESET;
      step_q <= 1'b0;
      wrap_q <= 1'b0;
    end else begin
      if (!counter_halt_q) begin
        presc_q <= presc_q + 7'h01;
      end
      step_q <= count_en;
      wrap_q <= count_en & at_mod;
      if (count_en) begin
        cnt_q <= at_mod ? CNT_RESET : cnt_q + 16'h0001;
      end
    end
  end

  // Counter low byte holding buffer for coherent 16-bit reads
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_buf_q <= 8'h00;
      cnt_latched_q <= 1'b0;
    end else if (wr_tsc && wdata[TSC_CLR]) begin
      cnt_buf_q <= 8'h00;
      cnt_latched_q <= 1'b0;
    end else if (rd_strobe && addr == ADDR_CNT_HI && !cnt_latched_q) begin
      cnt_buf_q <= cnt_q[7:0];
      cnt_latched_q <= 1'b1;
    end else if (rd_strobe && addr == ADDR_CNT_LO) begin
      cnt_latched_q <= 1'b0;
    end
  end

  // Modulo registers; a high byte write holds off the overflow flag
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mod_q <= MOD_RESET;
      mod_lock_q <= 1'b0;
    end else if (wr_strobe && addr == ADDR_MOD_HI) begin
      mod_q[15:8] <= wdata;
      mod_lock_q <= 1'b1;
    end else if (wr_strobe && addr == ADDR_MOD_LO) begin
      mod_q[7:0] <= wdata;
      mod_lock_q <= 1'b0;
    end
  end

  // Channel zero link bit and buffered value selection
  always_ff @(posedge clock) begin
    if (!nrst) begin
      channel_pair_link_q <= 1'b0;
      active_sel_q <= 1'b0;
      last_wr_q <= 1'b0;
    end else begin
      if (wr_strobe && addr == chan_reg(1'b0, CH_OFS_SC)) begin
        channel_pair_link_q <= wdata[SC_MSB];
      end
      if (!channel_pair_link_q) begin
        active_sel_q <= 1'b0;
        last_wr_q <= 1'b0;
      end else begin
        if (wr_vlo[1]) begin
          last_wr_q <= 1'b1;
        end else if (wr_vlo[0]) begin
          last_wr_q <= 1'b0;
        end
        if (wrap_q) begin
          active_sel_q <= last_wr_q;
        end
      end
    end
  end

  // Per channel mode decode, register file and output logic
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      logic lnk;
      logic wr_sc;
      logic rd_sc;
      logic wr_vhi;
      logic rd_vhi;
      logic rd_vlo;
      logic ch_clear;
      logic ch_set;
      logic live;
      logic [15:0] cmp_val;
      logic lock;
      logic rise;
      logic fall;

      // Link applies only to channel zero; it switches channel one off
      assign lnk = (gi == 0) ? channel_pair_link_q : 1'b0;
      assign ch_en[gi] = (gi == 0) ? 1'b1 : ~channel_pair_link_q;
      assign live = ch_en[gi] & (edge_level_q[gi] != ELS_OFF);
      assign capture_mode[gi] = live & ~lnk & ~channel_mode_bit_a_q[gi];
      assign compare_mode[gi] = live & (lnk | channel_mode_bit_a_q[gi]);

      assign wr_sc = wr_strobe && addr == chan_reg(1'(gi), CH_OFS_SC) && ch_en[gi];
      assign rd_sc = rd_strobe && addr == chan_reg(1'(gi), CH_OFS_SC) && ch_en[gi];
      assign wr_vhi = wr_strobe && addr == chan_reg(1'(gi), CH_OFS_VHI);
      assign wr_vlo[gi] = wr_strobe && addr == chan_reg(1'(gi), CH_OFS_VLO);
      assign rd_vhi = rd_strobe && addr == chan_reg(1'(gi), CH_OFS_VHI);
      assign rd_vlo = rd_strobe && addr == chan_reg(1'(gi), CH_OFS_VLO);

      // Compare source: in buffered mode the active value pair drives channel zero
      assign cmp_val = lnk ? val_q[active_sel_q] : val_q[gi];
      assign lock = lnk ? cmp_lock_q[active_sel_q] : cmp_lock_q[gi];
      assign match[gi] = step_q & compare_mode[gi] & ~lock & (cnt_q == cmp_val);

      // Active edge selection for capture, held off while halted or read-locked
      assign rise = edge_level_q[gi][0] & pin_s2_q[gi] & ~pin_prev_q[gi];
      assign fall = edge_level_q[gi][1] & ~pin_s2_q[gi] & pin_prev_q[gi];
      assign cap_ev[gi] = capture_mode[gi] & (rise | fall) & ~counter_halt_q & ~cap_lock_q[gi];

      assign ch_set = match[gi] | cap_ev[gi];
      assign ch_clear = wr_sc & ~wdata[SC_FLAG] & ch_armed_q[gi];

      // Status and control bits; the event flag keeps set over clear
      always_ff @(posedge clock) begin
        if (!nrst) begin
          channel_event_flag_q[gi] <= 1'b0;
          ch_armed_q[gi] <= 1'b0;
          channel_irq_enable_q[gi] <= 1'b0;
          channel_mode_bit_a_q[gi] <= 1'b0;
          edge_level_q[gi] <= ELS_OFF;
          toggle_on_wrap_q[gi] <= 1'b0;
          full_duty_force_q[gi] <= 1'b0;
        end else begin
          if (ch_set) begin
            channel_event_flag_q[gi] <= 1'b1;
          end else if (ch_clear) begin
            channel_event_flag_q[gi] <= 1'b0;
          end
          if (ch_set) begin
            ch_armed_q[gi] <= 1'b0;
          end else if (rd_sc && channel_event_flag_q[gi]) begin
            ch_armed_q[gi] <= 1'b1;
          end else if (wr_sc) begin
            ch_armed_q[gi] <= 1'b0;
          end
          if (wr_sc) begin
            channel_irq_enable_q[gi] <= wdata[SC_IE];
            channel_mode_bit_a_q[gi] <= wdata[SC_MSA];
            edge_level_q[gi] <= wdata[SC_ELS_LSB +: 2];
            toggle_on_wrap_q[gi] <= wdata[SC_TOV];
            full_duty_force_q[gi] <= wdata[SC_MAX];
          end
        end
      end

      // Channel value pair; capture takes the counter, compare writes lock until low byte
      always_ff @(posedge clock) begin
        if (!nrst) begin
          val_q[gi] <= CNT_RESET;
          cmp_lock_q[gi] <= 1'b0;
          cap_lock_q[gi] <= 1'b0;
        end else begin
          if (cap_ev[gi]) begin
            val_q[gi] <= cnt_q;
          end else if (wr_vhi) begin
            val_q[gi][15:8] <= wdata;
          end else if (wr_vlo[gi]) begin
            val_q[gi][7:0] <= wdata;
          end
          if (wr_vhi && (compare_mode[gi] || (gi == 1 && channel_pair_link_q))) begin
            cmp_lock_q[gi] <= 1'b1;
          end else if (wr_vlo[gi]) begin
            cmp_lock_q[gi] <= 1'b0;
          end
          if (rd_vhi && capture_mode[gi]) begin
            cap_lock_q[gi] <= 1'b1;
          end else if (rd_vlo) begin
            cap_lock_q[gi] <= 1'b0;
          end
        end
      end

      // Output level: preset when idle, wrap toggle beats a match
      always_ff @(posedge clock) begin
        if (!nrst) begin
          out_q[gi] <= 1'b1;
          max_act_q[gi] <= 1'b0;
        end else begin
          if (!live) begin
            out_q[gi] <= ~channel_mode_bit_a_q[gi];
          end else if (compare_mode[gi]) begin
            if (wrap_q && toggle_on_wrap_q[gi]) begin
              out_q[gi] <= ~out_q[gi];
            end else if (match[gi]) begin
              unique case (edge_level_q[gi])
                ELS_TOGGLE: out_q[gi] <= ~out_q[gi];
                ELS_CLEAR: out_q[gi] <= 1'b0;
                ELS_SET: out_q[gi] <= 1'b1;
                default: out_q[gi] <= out_q[gi];
              endcase
            end
          end
          if (!compare_mode[gi]) begin
            max_act_q[gi] <= 1'b0;
          end else if (wrap_q) begin
            max_act_q[gi] <= full_duty_force_q[gi] & toggle_on_wrap_q[gi];
          end
        end
      end

      // Full duty holds the pulse level, the complement of the compare action
      assign channel_pin_out[gi] = max_act_q[gi] ? ~edge_level_q[gi][0] : out_q[gi];
      assign channel_pin_timer[gi] = live;
      assign channel_pin_oe[gi] = compare_mode[gi];
      assign channel_irq[gi] = channel_event_flag_q[gi] & channel_irq_enable_q[gi] & ch_en[gi];
    end
  endgenerate

  // Read data, one cycle after the read strobe and zero otherwise
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (!rd_strobe) begin
      rdata_q <= 8'h00;
    end else begin
      unique case (addr)
        ADDR_TSC: rdata_q <= {overflow_flag_q, overflow_irq_enable_q, counter_halt_q, 2'b00, count_clock_select_q};
        ADDR_CNT_HI: rdata_q <= cnt_q[15:8];
        ADDR_CNT_LO: rdata_q <= cnt_latched_q ? cnt_buf_q : cnt_q[7:0];
        ADDR_MOD_HI: rdata_q <= mod_q[15:8];
        ADDR_MOD_LO: rdata_q <= mod_q[7:0];
        4'h5: rdata_q <= {channel_event_flag_q[0], channel_irq_enable_q[0], channel_pair_link_q,
                          channel_mode_bit_a_q[0], edge_level_q[0], toggle_on_wrap_q[0], full_duty_force_q[0]};
        4'h6: rdata_q <= val_q[0][15:8];
        4'h7: rdata_q <= val_q[0][7:0];
        4'h8: rdata_q <= ch_en[1] ? {channel_event_flag_q[1], channel_irq_enable_q[1], 1'b0,
                          channel_mode_bit_a_q[1], edge_level_q[1], toggle_on_wrap_q[1], full_duty_force_q[1]} : 8'h00;
        4'h9: rdata_q <= val_q[1][15:8];
        4'ha: rdata_q <= val_q[1][7:0];
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_q;

endmodule

`default_nettype wire

// ===== capcmp_timer_pkg.sv
// Shared constants for the two channel capture compare timer
package capcmp_timer_pkg;

  // Register indices on the byte wide register port
  localparam logic [3:0] ADDR_TSC = 4'h0;
  localparam logic [3:0] ADDR_CNT_HI = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO = 4'h2;
  localparam logic [3:0] ADDR_MOD_HI = 4'h3;
  localparam logic [3:0] ADDR_MOD_LO = 4'h4;
  localparam logic [3:0] ADDR_CH_BASE = 4'h5;
  localparam logic [3:0] CH_STRIDE = 4'h3;
  localparam logic [3:0] CH_OFS_SC = 4'h0;
  localparam logic [3:0] CH_OFS_VHI = 4'h1;
  localparam logic [3:0] CH_OFS_VLO = 4'h2;

  // Timer status and control fields
  localparam int TSC_OVF = 7;
  localparam int TSC_OIE = 6;
  localparam int TSC_HALT = 5;
  localparam int TSC_CLR = 4;
  localparam int TSC_PS_LSB = 0;

  // Channel status and control fields
  localparam int SC_FLAG = 7;
  localparam int SC_IE = 6;
  localparam int SC_MSB = 5;
  localparam int SC_MSA = 4;
  localparam int SC_ELS_LSB = 2;
  localparam int SC_TOV = 1;
  localparam int SC_MAX = 0;

  // Clock selection codes and reset values
  localparam logic [2:0] PS_EXT = 3'h7;
  localparam logic [2:0] PS_RESET = 3'h0;
  localparam logic HALT_RESET = 1'b1;
  localparam logic [15:0] MOD_RESET = 16'hffff;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [6:0] PRESC_ONES = 7'h7f;

  // Edge and level codes
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;

endpackage

// ===== timer_pin_model.sv
// Far side of the timer pins: external count clock source and channel pin levels
`timescale 1ns/1ps
`default_nettype none

module timer_pin_model (
  input wire logic clock,
  input wire logic ext_run,
  input wire logic [1:0] chan_level,
  output logic ext_count_clock_pin,
  output logic [1:0] channel_pin_in
);
  logic [2:0] ph_q;

  // Six bus clocks per count clock period, held low while not in use
  always_ff @(posedge clock) begin
    ph_q <= (ph_q == 3'h5 || !ext_run) ? 3'h0 : ph_q + 3'h1;
  end
  assign ext_count_clock_pin = ext_run && (ph_q < 3'h3);

  // Pin levels move only when the bench asks and then hold
  assign channel_pin_in = chan_level;
endmodule

`default_nettype wire

// ===== capcmp_timer_sva.sv
// Port checker for the two channel capture compare timer
`timescale 1ns/1ps
`default_nettype none

module capcmp_timer_sva
  import capcmp_timer_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [7:0] rdata,
  input wire logic port_direction_bit,
  input wire logic ext_pin_direction,
  input wire logic [1:0] channel_pin_out,
  input wire logic [1:0] channel_pin_oe,
  input wire logic [1:0] channel_pin_timer,
  input wire logic overflow_irq,
  input wire logic [1:0] channel_irq
);
  logic [7:0] tsc_q;
  logic [7:0] sc0_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // Shadow copies of the control bytes as written over the bus
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tsc_q <= 8'h20;
      sc0_q <= 8'h00;
    end else if (wr_strobe && addr == ADDR_TSC) begin
      tsc_q <= wdata;
    end else if (wr_strobe && addr == ADDR_CH_BASE) begin
      sc0_q <= wdata;
    end
  end

  // Steps: preset low asked for two cycles, a status read and its answer
  sequence preset_low_s;
    (sc0_q[SC_ELS_LSB +: 2] == ELS_OFF && sc0_q[SC_MSA]) [*2];
  endsequence
  sequence tsc_read_s;
    rd_strobe && addr == ADDR_TSC ##1 1'b1;
  endsequence

  // Pin ownership, requests and register answers tied to the control bits
  chk_ext_dir: assert property (ext_pin_direction == (port_direction_bit && tsc_q[2:0] != PS_EXT))
    else $error("external pin direction wrong");
  chk_clr_reads0: assert property (tsc_read_s |-> rdata[TSC_CLR] == 1'b0)
    else $error("counter clear bit read as one");
  chk_ovf_irq: assert property (overflow_irq |-> tsc_q[TSC_OIE])
    else $error("overflow request without enable");
  chk_ch_irq: assert property (channel_irq[0] |-> sc0_q[SC_IE])
    else $error("channel request without enable");
  chk_link_ch1: assert property (sc0_q[SC_MSB] |-> !channel_irq[1] && !channel_pin_timer[1] && !channel_pin_oe[1])
    else $error("linked channel one still active");
  chk_pin_mode: assert property (channel_pin_oe[0] == (sc0_q[SC_ELS_LSB +: 2] != ELS_OFF && (sc0_q[SC_MSA] || sc0_q[SC_MSB])))
    else $error("channel drive enable wrong for mode");
  chk_pin_owner: assert property (channel_pin_timer[0] == (sc0_q[SC_ELS_LSB +: 2] != ELS_OFF))
    else $error("channel pin ownership wrong");
  chk_preset_low: assert property (preset_low_s |-> !channel_pin_out[0])
    else $error("preset low level not applied");
endmodule

bind capcmp_timer capcmp_timer_sva u_capcmp_timer_sva (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .port_direction_bit(port_direction_bit),
  .ext_pin_direction(ext_pin_direction), .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
  .channel_pin_timer(channel_pin_timer), .overflow_irq(overflow_irq), .channel_irq(channel_irq));

`default_nettype wire

// ===== capcmp_timer_test.sv
// Register level test of the two channel capture compare timer
`timescale 1ns/1ps
`default_nettype none

module capcmp_timer_test;
  import capcmp_timer_pkg::*;
  logic clock, nrst, wr_strobe, rd_strobe, port_direction_bit, ext_run, ext_count_clock_pin;
  logic overflow_irq, ext_pin_direction;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, r;
  logic [1:0] channel_pin_in, chan_level, channel_pin_out, channel_pin_oe, channel_pin_timer, channel_irq;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int t1, hi;

  capcmp_timer u_capcmp_timer (.clock, .nrst, .addr, .wdata, .wr_strobe, .rd_strobe, .rdata,
    .ext_count_clock_pin, .port_direction_bit, .ext_pin_direction, .channel_pin_in, .channel_pin_out,
    .channel_pin_oe, .channel_pin_timer, .overflow_irq, .channel_irq);
  timer_pin_model u_timer_pin_model (.clock, .ext_run, .chan_level, .ext_count_clock_pin, .channel_pin_in);

  // Clock and cycle count
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  // Watchdog sized well above the longest expected run
  initial begin
    repeat (12000) @(posedge clock);
    n_fail++;
    finish_test();
  end

  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %0h, seen %0h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [3:0] a);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1 r = rdata;
    @(posedge clock);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string n);
    rd(a);
    check(n, 16'(e), 16'(r));
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wait_ovf;
    int k;
    k = 0;
    @(posedge clock);
    while (overflow_irq !== 1'b1 && k < 3000) begin
      @(posedge clock);
      k++;
    end
    check("ovf_seen", 16'h1, 16'(overflow_irq));
  endtask

  // Read then write back with the flag bit low, which clears a seen flag
  task automatic clear_ch0(input logic [7:0] w);
    rd(ADDR_CH_BASE);
    wr(ADDR_CH_BASE, w);
  endtask

  task automatic count_high;
    hi = 0;
    repeat (160) begin
      @(posedge clock);
      hi += int'(channel_pin_out[0] === 1'b1);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    port_direction_bit = 1'b1;
    {addr, wdata, wr_strobe, rd_strobe, ext_run, chan_level} = '0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rdchk(ADDR_TSC, 8'h20, "status_reset");
    rdchk(ADDR_MOD_HI, 8'hff, "mod_hi_reset");
    rdchk(ADDR_MOD_LO, 8'hff, "mod_lo_reset");
    rdchk(ADDR_CH_BASE, 8'h00, "sc0_reset");
    rdchk(4'hf, 8'h00, "unmapped");
    $display("test reset values done");
    wr(ADDR_MOD_HI, 8'h00);
    wr(ADDR_MOD_LO, 8'h0f);
    for (int ps = 0; ps < 8; ps++) begin
      ext_run <= (ps == 7);
      wr(ADDR_TSC, 8'h30);
      rd(ADDR_TSC);
      wr(ADDR_TSC, {5'h08, 3'(ps)});
      wait_ovf();
      t1 = cyc;
      rd(ADDR_TSC);
      wr(ADDR_TSC, {5'h08, 3'(ps)});
      wait_ovf();
      check("period", (ps == 7) ? 16'd96 : 16'(16 << ps), 16'(cyc - t1));
    end
    check("ext_dir", 16'h0, 16'(ext_pin_direction));
    ext_run <= 1'b0;
    $display("test count clock select done");
    wr(ADDR_TSC, 8'h30);
    check("port_dir", 16'h1, 16'(ext_pin_direction));
    rdchk(ADDR_TSC, 8'ha0, "flag_kept");
    wr(ADDR_TSC, 8'h20);
    rdchk(ADDR_TSC, 8'h20, "flag_cleared");
    wr(ADDR_TSC, 8'ha0);
    rdchk(ADDR_TSC, 8'h20, "flag_write_one");
    rdchk(ADDR_CNT_HI, 8'h00, "cnt_hi_stopped");
    rdchk(ADDR_CNT_LO, 8'h00, "cnt_lo_stopped");
    $display("test overflow flag done");
    wr(ADDR_TSC, 8'h16);
    idle(25);
    rdchk(ADDR_CNT_HI, 8'h00, "cnt_hi");
    idle(150);
    rdchk(ADDR_CNT_HI, 8'h00, "cnt_hi_again");
    rdchk(ADDR_CNT_LO, 8'h00, "cnt_lo_latched");
    wr(ADDR_TSC, 8'h30);
    wr(ADDR_MOD_HI, 8'h00);
    wr(ADDR_TSC, 8'h00);
    idle(60);
    rdchk(ADDR_TSC, 8'h00, "mod_locked");
    wr(ADDR_MOD_LO, 8'h0f);
    idle(40);
    rdchk(ADDR_TSC, 8'h80, "mod_unlocked");
    $display("test counter and modulo done");
    for (int c = 1; c < 4; c++) begin
      wr(ADDR_TSC, 8'h30);
      wr(ADDR_CH_BASE, {4'h4, 2'(c), 2'h0});
      wr(ADDR_TSC, 8'h00);
      chan_level <= 2'b01;
      idle(8);
      check("rise_capture", 16'(c != 2), 16'(channel_irq[0]));
      clear_ch0({4'h4, 2'(c), 2'h0});
      chan_level <= 2'b00;
      idle(8);
      check("fall_capture", 16'(c != 1), 16'(channel_irq[0]));
      clear_ch0({4'h4, 2'(c), 2'h0});
    end
    wr(ADDR_TSC, 8'h20);
    chan_level <= 2'b01;
    idle(8);
    check("halt_capture", 16'h0, 16'(channel_irq[0]));
    chan_level <= 2'b00;
    $display("test input capture done");
    wr(ADDR_CH_BASE + CH_OFS_VHI, 8'h00);
    wr(ADDR_CH_BASE + CH_OFS_VLO, 8'h05);
    for (int c = 1; c < 4; c++) begin
      wr(ADDR_TSC, 8'h30);
      wr(ADDR_CH_BASE, (c == 3) ? 8'h10 : 8'h00);
      idle(2);
      check("preset", 16'(c != 3), 16'(channel_pin_out[0]));
      wr(ADDR_CH_BASE, {4'h1, 2'(c), 2'h0});
      wr(ADDR_TSC, 8'h00);
      idle(12);
      check("compare_out", 16'(c == 3), 16'(channel_pin_out[0]));
      rd(ADDR_CH_BASE);
      check("compare_flag", 16'h1, 16'(r[SC_FLAG]));
      wr(ADDR_CH_BASE, {4'h1, 2'(c), 2'h0});
    end
    $display("test output compare done");
    wr(ADDR_TSC, 8'h30);
    wr(ADDR_CH_BASE, 8'h1a);
    wr(ADDR_TSC, 8'h00);
    idle(32);
    count_high();
    check("pwm_duty", 16'h1, 16'(hi inside {[50:70]}));
    wr(ADDR_CH_BASE, 8'h1b);
    idle(40);
    count_high();
    check("full_duty", 16'd160, 16'(hi));
    $display("test pwm done");
    wr(ADDR_TSC, 8'h30);
    wr(4'h8, 8'h0c);
    wr(ADDR_CH_BASE, 8'h28);
    rdchk(4'h8, 8'h00, "ch1_linked");
    check("ch1_pin", 16'h0, 16'(channel_pin_timer[1]));
    $display("test channel link done");
    finish_test();
  end
endmodule

`default_nettype wire
